// *** design/phy_np_gig_regs.sv ***
/*
  APB register slice for auto-negotiation next pages and the gigabit
  control/status registers. Assumes the negotiation engine outside
  drives page and status events synchronous to pclk, and that the
  strap pins are stable around reset release.
*/
// Our own choice: register access over APB.
`timescale 1ns/1ns

module phy_np_gig_regs
  import phy_np_gig_pkg::*;
#(
  parameter int addr_width = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [addr_width-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [1:0] config_pin_strap,
  input wire logic tx_page_sent,
  input wire logic tx_page_toggle,
  input wire logic rx_page_valid,
  input wire next_page_t rx_page,
  input wire gig_stat_t gig_stat,
  input wire logic ms_fault_event,
  input wire logic idle_err_event,
  output next_page_t tx_page,
  output gig_ctrl_t gig_ctrl,
  output logic eff_manual_master,
  output logic eff_manual_slave
);

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [addr_width-1:0] a,
                               input logic [7:0] idx);
    hit = (a == addr_width'({idx, 2'b00}));
  endfunction

  logic access;
  logic wr;
  logic rd;
  logic mapped;
  logic [15:0] wdata;
  logic [1:0] lane_en;

  assign access = psel && penable && clk_en;
  assign wr = access && pwrite;
  // Snapshot and clear share the setup edge, so no event is lost between
  assign rd = psel && !penable && !pwrite && clk_en;
  assign mapped = hit(paddr, idx_an_next_page_tx)
    || hit(paddr, idx_an_partner_next_page_rx)
    || hit(paddr, idx_gigabit_control)
    || hit(paddr, idx_gigabit_status);
  assign wdata = pwdata[15:0];
  assign lane_en = pstrb[1:0];
  // Zero wait states: every access completes in its first access cycle
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // ----------------------------------------------------------------
  // Transmit next page
  // ----------------------------------------------------------------
  logic tx_more;
  logic tx_msg;
  logic tx_ack2;
  logic tx_toggle;
  logic [10:0] tx_code;
  logic wr_tx;

  assign wr_tx = wr && hit(paddr, idx_an_next_page_tx);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_more <= 1'b0;
      tx_msg <= np_msg_reset;
      tx_ack2 <= 1'b0;
      tx_code <= np_code_reset;
    end else if (wr_tx) begin
      if (lane_en[1]) begin
        tx_more <= wdata[np_more_bit];
        tx_msg <= wdata[np_msg_bit];
        tx_ack2 <= wdata[np_ack2_bit];
        tx_code[10:8] <= wdata[np_code_hi:8];
      end
      if (lane_en[0]) begin
        tx_code[7:0] <= wdata[7:0];
      end
    end
  end

  // Toggle follows the inverse of the last word sent; software cannot set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_toggle <= 1'b0;
    end else if (clk_en && tx_page_sent) begin
      tx_toggle <= !tx_page_toggle;
    end
  end

  assign tx_page = '{more: tx_more, ack: 1'b0, msg: tx_msg,
                     ack2: tx_ack2, toggle: tx_toggle, code: tx_code};

  // ----------------------------------------------------------------
  // Received next page
  // ----------------------------------------------------------------
  next_page_t rx_reg;

  // Whole word loads in one edge, so reads never mix two pages
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_reg <= '0;
    end else if (clk_en && rx_page_valid) begin
      rx_reg <= rx_page;
    end
  end

  // ----------------------------------------------------------------
  // Gigabit control
  // ----------------------------------------------------------------
  logic [2:0] test_mode;
  logic manual;
  logic force_master;
  logic multi_port;
  logic adv_fdx;
  logic adv_hdx;
  logic [7:0] ctrl_spare;
  logic wr_ctrl;
  logic strap_load;
  logic [1:0] strap_s1;
  logic [1:0] strap_s2;
  logic [1:0] strap_s3;
  logic [2:0] strap_fill;
  logic strap_take;

  assign wr_ctrl = wr && hit(paddr, idx_gigabit_control);
  // Stages must hold pin samples before they count as agreeing
  assign strap_take = strap_load && strap_fill[2] && strap_s2 == strap_s3;

  // Strap pins are asynchronous: three stages, load when the last two stages agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_s1 <= 2'h0;
      strap_s2 <= 2'h0;
      strap_s3 <= 2'h0;
      strap_fill <= 3'h0;
      strap_load <= 1'b1;
    end else if (clk_en) begin
      strap_s1 <= config_pin_strap;
      strap_s2 <= strap_s1;
      strap_s3 <= strap_s2;
      strap_fill <= {strap_fill[1:0], 1'b1};
      if (strap_take) begin
        strap_load <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      test_mode <= test_normal;
      manual <= 1'b0;
      force_master <= 1'b0;
      multi_port <= 1'b0;
      ctrl_spare <= 8'h00;
    end else if (wr_ctrl) begin
      if (lane_en[1]) begin
        // Reserved codes are stored as written; behaviour is undefined
        test_mode <= wdata[15:gc_test_lo];
        manual <= wdata[gc_manual_bit];
        force_master <= wdata[gc_master_bit];
        multi_port <= wdata[gc_port_bit];
      end
      if (lane_en[0]) begin
        ctrl_spare <= wdata[7:0];
      end
    end
  end

  // Strap value loads once after release; later writes override it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      adv_fdx <= 1'b0;
      adv_hdx <= 1'b0;
    end else if (wr_ctrl && lane_en[1]) begin
      adv_fdx <= wdata[gc_fdx_bit];
      adv_hdx <= wdata[gc_hdx_bit];
    end else if (clk_en && strap_take) begin
      adv_fdx <= strap_s3[1];
      adv_hdx <= strap_s3[0];
    end
  end

  assign gig_ctrl = '{test_mode: test_mode, manual: manual,
                      force_master: force_master, multi_port: multi_port,
                      adv_fdx: adv_fdx, adv_hdx: adv_hdx};
  assign eff_manual_master = manual && force_master;
  assign eff_manual_slave = manual && !force_master;

  // ----------------------------------------------------------------
  // Gigabit status
  // ----------------------------------------------------------------
  logic ms_fault;
  logic is_master;
  logic [7:0] idle_err;
  logic rd_stat;

  assign rd_stat = rd && hit(paddr, idx_gigabit_status);

  // Event in the read cycle survives: set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ms_fault <= 1'b0;
    end else if (clk_en && ms_fault_event) begin
      ms_fault <= 1'b1;
    end else if (rd_stat) begin
      ms_fault <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      is_master <= gs_master_reset;
    end else if (clk_en) begin
      is_master <= gig_stat.is_master;
    end
  end

  // An error in the read cycle restarts the count at one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_err <= idle_err_reset;
    end else if (rd_stat) begin
      idle_err <= idle_err_event ? 8'h01 : idle_err_reset;
    end else if (clk_en && idle_err_event && idle_err != idle_err_max) begin
      idle_err <= idle_err + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  logic [15:0] next_rdata;

  always_comb begin
    next_rdata = 16'h0000;
    if (hit(paddr, idx_an_next_page_tx)) begin
      next_rdata = {tx_more, 1'b0, tx_msg, tx_ack2, tx_toggle, tx_code};
    end else if (hit(paddr, idx_an_partner_next_page_rx)) begin
      next_rdata = rx_reg;
    end else if (hit(paddr, idx_gigabit_control)) begin
      next_rdata = {test_mode, manual, force_master, multi_port,
                    adv_fdx, adv_hdx, ctrl_spare};
    end else if (hit(paddr, idx_gigabit_status)) begin
      next_rdata = {ms_fault, is_master,
                    gig_stat.local_rx_ok, gig_stat.remote_rx_ok,
                    gig_stat.lp_fdx, gig_stat.lp_hdx,
                    2'b00, idle_err};
    end
  end

  // Read data registered at the setup cycle, valid in the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd) begin
      prdata <= {16'h0000, next_rdata};
    end
  end

endmodule // phy_np_gig_regs

// *** design/phy_np_gig_pkg.sv ***
/*
  Package for the next-page and gigabit control/status register slice:
  register offsets, field positions, reset values and carrier structs.
  Assumes a 32-bit APB slave with one register per aligned word.
*/
package phy_np_gig_pkg;

  // ----------------------------------------------------------------
  // Register indices; byte address is the index times four
  // ----------------------------------------------------------------
  localparam logic [7:0] idx_an_next_page_tx = 8'h07;
  localparam logic [7:0] idx_an_partner_next_page_rx = 8'h08;
  localparam logic [7:0] idx_gigabit_control = 8'h09;
  localparam logic [7:0] idx_gigabit_status = 8'h0a;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int np_more_bit = 15;
  localparam int np_ack_bit = 14;
  localparam int np_msg_bit = 13;
  localparam int np_ack2_bit = 12;
  localparam int np_toggle_bit = 11;
  localparam int np_code_hi = 10;

  localparam int gc_test_lo = 13;
  localparam int gc_manual_bit = 12;
  localparam int gc_master_bit = 11;
  localparam int gc_port_bit = 10;
  localparam int gc_fdx_bit = 9;
  localparam int gc_hdx_bit = 8;

  localparam int gs_fault_bit = 15;
  localparam int gs_master_bit = 14;
  localparam int gs_lrx_bit = 13;
  localparam int gs_rrx_bit = 12;
  localparam int gs_lp_fdx_bit = 11;
  localparam int gs_lp_hdx_bit = 10;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [10:0] np_code_reset = 11'h001;
  localparam logic np_msg_reset = 1'b1;
  localparam logic gs_master_reset = 1'b1;
  localparam logic [7:0] idle_err_reset = 8'h00;
  localparam logic [7:0] idle_err_max = 8'hff;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    test_normal     = 3'b000,
    test_waveform   = 3'b001,
    test_jitter_mst = 3'b010,
    test_jitter_slv = 3'b011,
    test_distortion = 3'b100
  } test_mode_t;

  // Next-page word as carried on the link side
  typedef struct packed {
    logic more;
    logic ack;
    logic msg;
    logic ack2;
    logic toggle;
    logic [10:0] code;
  } next_page_t;

  // Gigabit control settings handed to the negotiation engine
  typedef struct packed {
    logic [2:0] test_mode;
    logic manual;
    logic force_master;
    logic multi_port;
    logic adv_fdx;
    logic adv_hdx;
  } gig_ctrl_t;

  // Status reported by the negotiation engine and receivers
  typedef struct packed {
    logic is_master;
    logic local_rx_ok;
    logic remote_rx_ok;
    logic lp_fdx;
    logic lp_hdx;
  } gig_stat_t;

endpackage

// *** test/phy_np_gig_regs_checker.sv ***
/* Assertions on the register slice ports.
   Assumes a bind to phy_np_gig_regs; one clock, async reset. */
`timescale 1ns/1ns
module phy_np_gig_regs_checker
  import phy_np_gig_pkg::*;
#(
  parameter int addr_width = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [addr_width-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic tx_page_sent,
  input wire logic tx_page_toggle,
  input wire next_page_t tx_page,
  input wire gig_ctrl_t gig_ctrl,
  input wire logic eff_manual_master,
  input wire logic eff_manual_slave
);
  logic wr;
  logic wgc;
  logic [13:0] txf;
  assign wr = psel && penable && pwrite && clk_en;
  assign wgc = wr && paddr == 12'h024 && pstrb[1];
  assign txf = {tx_page.more, tx_page.msg, tx_page.ack2, tx_page.code};
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_reset_vals:
    assert property ($rose(presetn) |-> tx_page == 16'h2001)
    else $error("tx word reset value");
  a_eff_master:
    assert property (eff_manual_master ==
      (gig_ctrl.manual && gig_ctrl.force_master)) else $error("eff master");
  a_eff_slave:
    assert property (eff_manual_slave ==
      (gig_ctrl.manual && !gig_ctrl.force_master)) else $error("eff slave");
  a_toggle_inv:
    assert property (tx_page_sent && clk_en |=>
      tx_page.toggle == !$past(tx_page_toggle)) else $error("tx toggle");
  a_tx_write:
    assert property (wr && paddr == 12'h01c && pstrb[1:0] == 2'b11 |=>
      txf == {$past(pwdata[15]), $past(pwdata[13:12]),
              $past(pwdata[10:0])})
    else $error("tx write");
  a_tx_hold:
    assert property (!(wr && paddr == 12'h01c) |=> $stable(txf))
    else $error("tx changed");
  a_ctrl_write:
    assert property (wgc |=> gig_ctrl == $past(pwdata[15:8]))
    else $error("ctrl write");
  a_ctrl_hold:
    assert property (!wgc && clk_en |=> $stable(gig_ctrl[7:2]))
    else $error("ctrl changed");
endmodule // phy_np_gig_regs_checker

bind phy_np_gig_regs phy_np_gig_regs_checker
  #(.addr_width(addr_width)) i_chk (
  .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pstrb(pstrb), .tx_page_sent(tx_page_sent),
  .tx_page_toggle(tx_page_toggle), .tx_page(tx_page), .gig_ctrl(gig_ctrl),
  .eff_manual_master(eff_manual_master),
  .eff_manual_slave(eff_manual_slave)
);

// *** test/link_partner_model.sv ***
/* Far side model: negotiation engine events, pages and status.
   Assumes pclk from the bench and one task call at a time. */
`timescale 1ns/1ns
module link_partner_model
  import phy_np_gig_pkg::*;
(
  input wire logic pclk,
  output logic tx_page_sent,
  output logic tx_page_toggle,
  output logic rx_page_valid,
  output next_page_t rx_page,
  output gig_stat_t gig_stat,
  output logic ms_fault_event,
  output logic idle_err_event
);
  logic [3:0] ev;
  assign {tx_page_sent, rx_page_valid, ms_fault_event, idle_err_event} = ev;
  initial begin
    ev = 4'h0;
    tx_page_toggle = 1'b1;
    rx_page = 16'h5a5a;
    gig_stat = 5'h10;
  end
  // Data lines carry the inverse off the strobe, so a late capture shows
  task automatic pulse(input logic [3:0] k, input next_page_t w);
    @(posedge pclk);
    ev <= k;
    tx_page_toggle <= w.toggle;
    rx_page <= w;
    @(posedge pclk);
    ev <= 4'h0;
    tx_page_toggle <= ~w.toggle;
    rx_page <= ~w;
  endtask
  task automatic set_stat(input gig_stat_t g);
    @(posedge pclk);
    gig_stat <= g;
  endtask
endmodule // link_partner_model

// *** test/test_gige_phy_nextpage_1000t_regs.sv ***
/* Self-checking bench for the register slice, APB master side.
   Assumes the package, design, checker and link partner model. */
`timescale 1ns/1ns
`define CHK(n, e, a) chk(n, 32'(e), 32'(a))
module test_gige_phy_nextpage_1000t_regs
  import phy_np_gig_pkg::*;
;
  logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [3:0] pstrb;
  logic [1:0] config_pin_strap;
  logic tx_page_sent, tx_page_toggle, rx_page_valid, rerr;
  logic ms_fault_event, idle_err_event, eff_manual_master, eff_manual_slave;
  next_page_t rx_page, tx_page;
  gig_stat_t gig_stat, gs;
  gig_ctrl_t gig_ctrl;
  logic [15:0] s;
  int err_count = 0;
  int n_checks = 0;
  phy_np_gig_regs #(.addr_width(12)) i_dut (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .config_pin_strap(config_pin_strap), .tx_page_sent(tx_page_sent),
    .tx_page_toggle(tx_page_toggle), .rx_page_valid(rx_page_valid),
    .rx_page(rx_page), .gig_stat(gig_stat), .ms_fault_event(ms_fault_event),
    .idle_err_event(idle_err_event), .tx_page(tx_page), .gig_ctrl(gig_ctrl),
    .eff_manual_master(eff_manual_master),
    .eff_manual_slave(eff_manual_slave)
  );
  link_partner_model i_link (
    .pclk(pclk), .tx_page_sent(tx_page_sent), .tx_page_toggle(tx_page_toggle),
    .rx_page_valid(rx_page_valid), .rx_page(rx_page), .gig_stat(gig_stat),
    .ms_fault_event(ms_fault_event), .idle_err_event(idle_err_event)
  );
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  // Toggle reads back inverted; bit 14 always reads zero
  function automatic logic [15:0] tx_exp(input logic [15:0] w);
    return {w[15], 1'b0, w[13:12], ~w[11], w[10:0]};
  endfunction
  function automatic logic [15:0] st_exp(input logic f, input gig_stat_t g,
                                         input logic [7:0] c);
    return {f, g, 2'b00, c};
  endfunction
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] a);
    n_checks++;
    if (a !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", n, e, a);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [15:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, 16'h0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never completes
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (4000) @(posedge pclk);
    err_count++;
    test_done();
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = 48'h0;
    clk_en = 1'b1;
    pstrb = 4'hf;
    config_pin_strap = 2'b10;
    s = 16'h0030;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    // Strap takes a few edges to settle into the control word
    repeat (6) @(posedge pclk);
    apb(1'b0, 12'h024, 16'h0000);
    `CHK("ctrl reset", 16'h0200, rdat);
    apb(1'b0, 12'h01c, 16'h0000);
    `CHK("tx reset", 16'h2001, rdat);
    apb(1'b0, 12'h020, 16'h0000);
    `CHK("rx reset", 16'h0000, rdat);
    apb(1'b0, 12'h028, 16'h0000);
    `CHK("status reset", 16'h4000, rdat);
    repeat (4) begin
      s = lfsr(s);
      apb(1'b1, 12'h01c, s);
      i_link.pulse(4'h8, s);
      apb(1'b0, 12'h01c, 16'h0000);
      `CHK("tx page", tx_exp(s), rdat);
    end
    repeat (3) begin
      s = lfsr(s);
      i_link.pulse(4'h4, s);
      apb(1'b1, 12'h020, ~s);
      apb(1'b0, 12'h020, 16'h0000);
      `CHK("rx page", s, rdat);
    end
    for (int m = 0; m < 8; m++) begin
      s = lfsr(s);
      s[15:13] = m[2:0];
      apb(1'b1, 12'h024, s);
      apb(1'b0, 12'h024, 16'h0000);
      `CHK("ctrl", s, rdat);
      `CHK("master", s[12] & s[11], eff_manual_master);
      `CHK("slave", s[12] & ~s[11], eff_manual_slave);
    end
    s = lfsr(s);
    gs = s[4:0];
    i_link.set_stat(gs);
    repeat (3) i_link.pulse(4'h3, s);
    apb(1'b0, 12'h028, 16'h0000);
    `CHK("status", st_exp(1'b1, gs, 8'h03), rdat);
    apb(1'b0, 12'h028, 16'h0000);
    `CHK("status cleared", st_exp(1'b0, gs, 8'h00), rdat);
    repeat (300) i_link.pulse(4'h1, s);
    apb(1'b0, 12'h028, 16'h0000);
    `CHK("count full", st_exp(1'b0, gs, 8'hff), rdat);
    // Mid-run reset must bring the transmit word back to its reset value
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h01c, 16'h0000);
    `CHK("tx after reset", 16'h2001, rdat);
    apb(1'b0, 12'h028, 16'h0000);
    `CHK("status after reset", st_exp(1'b0, gs, 8'h00), rdat);
    apb(1'b0, 12'h02c, 16'h0000);
    `CHK("unmapped error", 1'b1, rerr);
    test_done();
  end
endmodule // test_gige_phy_nextpage_1000t_regs
